// [src/anm_mux.v]
`timescale 1ns/10ps
`default_nettype none
`include "anm_defines.vh"

module anm_mux (
  // clocks and reset
  input wire clk,
  input wire rstn,
  input wire read_clk,
  // converter words
  input wire [`ANM_WORD_W-1:0] first_sample_word,
  input wire [`ANM_WORD_W-1:0] second_sample_word,
  // output to the link transmitter
  output reg [`ANM_NIB_W-1:0] nibble_output
);

  // ========================================================
  // phase codes, one per write cycle of a frame
  localparam [`ANM_PH_W-1:0] PH_IDLE = `ANM_PH_IDLE; // gap cycles of the slow mode
  localparam [`ANM_PH_W-1:0] PH_CAPT = `ANM_PH_CAPT; // words latched at end of this cycle
  localparam [`ANM_PH_W-1:0] PH_A_LO = 3'h2;
  localparam [`ANM_PH_W-1:0] PH_A_MID = 3'h3;
  localparam [`ANM_PH_W-1:0] PH_A_HI = 3'h4;
  localparam [`ANM_PH_W-1:0] PH_B_LO = 3'h5;
  localparam [`ANM_PH_W-1:0] PH_B_MID = `ANM_PH_LAST; // last counted phase
  localparam [`ANM_PH_W-1:0] PH_SPARE = 3'h7; // never entered

  // ========================================================
  // internal state
  // read clock sampled on the previous write edge
  reg read_prev_reg;
  // write-clock phase within the sampling period
  reg [`ANM_PH_W-1:0] phase_reg;
  reg [`ANM_PH_W-1:0] phase_next;
  // input latches for the two converter words
  reg [`ANM_WORD_W-1:0] word_a_reg;
  reg [`ANM_WORD_W-1:0] word_b_reg;
  // slice chosen for the next output period
  reg [`ANM_NIB_W-1:0] slice_reg;
  reg [`ANM_NIB_W-1:0] slice_next;
  // one-cycle pulse on each read clock rise
  wire read_rise;
  // latch strobe for the input words
  wire capture_en;

  // read clock history; reset high so a high level at release is no edge
  // history only; no reset dependency needed for steady run
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_prev_reg <= 1'b1;
    end else begin
      read_prev_reg <= read_clk;
    end
  end

  assign read_rise = read_clk & ~read_prev_reg;

  // latch one write cycle after the rise, unless a new rise cuts in
  assign capture_en = (phase_reg == PH_CAPT) & ~read_rise;

  // ========================================================
  // phase counter: 1 = capture edge, 2..6 = slices, 0 = idle
  always @* begin
    phase_next = phase_reg;
    if (read_rise) begin
      // every read rise realigns, even mid-frame
      phase_next = PH_CAPT;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          // hold until a read rise restarts the frame
          phase_next = PH_IDLE;
        end

        PH_CAPT: begin
          // selection sequence starts at the capture edge
          phase_next = PH_A_LO;
        end

        PH_A_LO: begin
          // first word middle slice next
          phase_next = PH_A_MID;
        end

        PH_A_MID: begin
          // first word high slice next
          phase_next = PH_A_HI;
        end

        PH_A_HI: begin
          // second word low slice next
          phase_next = PH_B_LO;
        end

        PH_B_LO: begin
          // second word middle slice next
          phase_next = PH_B_MID;
        end

        PH_B_MID: begin
          // frame done unless a rise restarts it
          phase_next = PH_IDLE;
        end

        default: begin
          // spare code falls back to waiting
          phase_next = PH_IDLE;
        end
      endcase
    end
  end

  // phase register, cleared by reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= `ANM_PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ========================================================
  // input latches, loaded on the capture edge
  // first word latch
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_a_reg <= `ANM_WORD_RST;
    end else if (capture_en) begin
      word_a_reg <= first_sample_word;
    end
  end

  // second word latch
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_b_reg <= `ANM_WORD_RST;
    end else if (capture_en) begin
      word_b_reg <= second_sample_word;
    end
  end

  // ========================================================
  // slice selection for the current phase
  always @* begin
    slice_next = slice_reg;
    case (phase_reg)
      PH_A_LO: begin
        // first word, bits 3..0
        slice_next = word_a_reg[3:0];
      end

      PH_A_MID: begin
        // first word, bits 7..4
        slice_next = word_a_reg[7:4];
      end

      PH_A_HI: begin
        // first word, bits 11..8
        slice_next = word_a_reg[11:8];
      end

      PH_B_LO: begin
        // second word, bits 3..0
        slice_next = word_b_reg[3:0];
      end

      PH_B_MID: begin
        // second word, bits 7..4
        slice_next = word_b_reg[7:4];
      end

      PH_CAPT: begin
        // sixth slice when the next frame has already begun
        slice_next = word_b_reg[11:8];
      end

      PH_IDLE: begin
        // sixth slice, repeated through the slow-mode gap
        slice_next = word_b_reg[11:8];
      end

      default: begin
        slice_next = slice_reg;
      end
    endcase
  end

  // slice register, half a write cycle ahead of the pin
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slice_reg <= `ANM_NIB_RST;
    end else begin
      slice_reg <= slice_next;
    end
  end

  // ========================================================
  // output launched on falling edge for receiver margin
  // receiver captures it half a period later
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      nibble_output <= `ANM_NIB_RST;
    end else begin
      nibble_output <= slice_reg;
    end
  end

endmodule // anm_mux
`default_nettype wire

// [src/anm_defines.vh]
`ifndef ANM_DEFINES_VH
`define ANM_DEFINES_VH
// ==========================================================
// widths
`define ANM_WORD_W 12
`define ANM_NIB_W 4
`define ANM_PH_W 3
// ==========================================================
// phase codes: idle phase, capture phase and last slice phase
`define ANM_PH_IDLE 3'h0
`define ANM_PH_CAPT 3'h1
`define ANM_PH_LAST 3'h6
// ==========================================================
// reset values
`define ANM_NIB_RST 4'h0
`define ANM_WORD_RST 12'h000
`endif

// [sim/anm_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// slice order and reset value checks
module anm_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // converter side
  input wire logic read_clk,
  input wire logic [11:0] first_sample_word,
  input wire logic [11:0] second_sample_word,
  // link side
  input wire logic [3:0] nibble_output
);
  // read clock rise as seen on the write clock
  sequence s_go;
    $rose(read_clk);
  endsequence
  // reset just released
  sequence s_rel;
    !rstn ##1 rstn;
  endsequence
  property p_ord;
    logic [11:0] a, b;
    @(posedge clk) disable iff (!rstn) s_go ##1 (1, a = first_sample_word,
      b = second_sample_word) |-> ##2 nibble_output == a[3:0] ##1 nibble_output == a[7:4]
      ##1 nibble_output == a[11:8] ##1 nibble_output == b[3:0] ##1 nibble_output == b[7:4]
      ##1 nibble_output == b[11:8];
  endproperty
  a_ord: assert property (p_ord) else $error("slice order wrong");
  property p_rst;
    @(posedge clk) !rstn |-> nibble_output == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("output not cleared");
  property p_first;
    logic [11:0] a;
    @(posedge clk) disable iff (!rstn) s_go ##1 (1, a = first_sample_word)
      |-> ##2 nibble_output == a[3:0];
  endproperty
  a_first: assert property (p_first) else $error("first slice late");
  property p_word_b;
    logic [11:0] b;
    @(posedge clk) disable iff (!rstn) s_go ##1 (1, b = second_sample_word)
      |-> ##5 nibble_output == b[3:0] ##1 nibble_output == b[7:4]
      ##1 nibble_output == b[11:8];
  endproperty
  a_word_b: assert property (p_word_b) else $error("second word slices wrong");
  property p_idle;
    logic [11:0] b;
    @(posedge clk) disable iff (!rstn) s_go ##1 (1, b = second_sample_word) ##7 s_go
      |-> ##1 nibble_output == b[11:8] ##1 nibble_output == b[11:8];
  endproperty
  a_idle: assert property (p_idle) else $error("gap cycles not held");
  property p_rel;
    @(posedge clk) s_rel |-> nibble_output == 4'h0;
  endproperty
  a_rel: assert property (p_rel) else $error("output not zero after release");
endmodule // anm_properties
bind anm_mux anm_properties anm_properties_i (.*);
`default_nettype wire

// [sim/anm_adc_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// sampling clock, write clock over per
module anm_adc_model (
  // write clock and period select
  input wire logic clk,
  input wire logic [3:0] per,
  // shared sampling clock
  output var logic read_clk = 1'b0
);
  logic [3:0] cnt_reg = 4'h0;
  // divide on falling edge, shared by converters
  always @(negedge clk) begin
    cnt_reg <= (cnt_reg + 4'h1 >= per) ? 4'h0 : cnt_reg + 4'h1;
    read_clk <= (cnt_reg < per / 2);
  end
endmodule // anm_adc_model
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// bench top
module testbench;
  logic clk = 0, rstn = 1, rc = 0;
  logic [3:0] per = 4'h6, nib;
  logic [11:0] wa = 12'h0000, wb = 12'h0000;
  logic [23:0] s = 24'h00_0039;
  logic [8:0] h = 9'h000;
  logic [3:0] q[$];
  int bad_count = 0, check_count = 0, cyc = 0;
  wire read_clk;
  always #10 clk = ~clk;
  anm_adc_model anm_adc_model_i (.clk(clk), .per(per), .read_clk(read_clk));
  anm_mux anm_mux_i (.clk(clk), .rstn(rstn), .read_clk(read_clk), .first_sample_word(wa),
    .second_sample_word(wb), .nibble_output(nib));
  function logic [23:0] lfsr(input logic [23:0] v);
    return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
  endfunction
  task finish_test;
    if (q.size() != 0) bad_count++; // notes never matched by an output
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp_nib(input logic [3:0] e, input logic [3:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected nibble_output %h %h", e, g);
    end
  endtask
  // words valid only between first and second falling write edge after rise
  initial begin
    #1 rstn = 0; // a real falling edge for the async clear
    repeat (2) @(negedge clk);
    rstn = 1;
    for (int f = 0; f < 12; f++) begin
      @(posedge read_clk);
      if (f == 6) per = 4'h8;
      s = lfsr(s);
      {wa, wb} = ~s;
      @(negedge clk);
      {wa, wb} = s;
      for (int k = 0; k < 6; k++) q.push_back(4'(s >> (k < 3 ? 12 + 4 * k : 4 * k - 12)));
      @(negedge clk);
      {wa, wb} = ~s;
    end
    repeat (12) @(negedge clk);
    finish_test;
  end
  // receiver samples slices three to eight edges after each rise
  always @(posedge clk) begin
    h = rstn ? {h[7:0], read_clk & ~rc} : 9'h000;
    rc = read_clk;
    if (++cyc > 600) begin
      bad_count++;
      finish_test;
    end
    if (|h[8:3] && q.size() > 0) cmp_nib(q.pop_front(), nib);
  end
endmodule // testbench
`default_nettype wire
